// ### rtl/main_clock_select_prescale_control.sv
// Clock controller registers: main source select, prescaler, lock, status, fast osc trims.
// Assumes an AXI4-Lite master on the bus structs and oscillator status synchronous to clk.
//
// The AXI4-Lite register port is this design's own decision.
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"

module main_clock_select_prescale_control #(
    parameter logic [5:0] FREQ_TRIM_16 = 6'h20,
    parameter logic [5:0] FREQ_TRIM_20 = 6'h20,
    parameter logic [3:0] TEMP_TRIM_16 = 4'h8,
    parameter logic [3:0] TEMP_TRIM_20 = 4'h8,
    parameter int DIV_CNT_W = 7
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire clk_ctrl_pkg::axi_req_s axi_i,
    output clk_ctrl_pkg::axi_rsp_s axi_o,
    input wire logic protect_open_i,
    input wire logic sleep_i,
    input wire logic sysclk_in_use_i,
    input wire logic [3:0] periph_request_i,
    input wire logic [3:0] source_ready_i,
    input wire logic fast_osc_tick_i,
    input wire logic fuse_frequency_select_i,
    input wire logic fuse_calibration_lock_i,
    output logic system_clock_pin_output_o,
    output clk_ctrl_pkg::src_e main_source_active_o,
    output logic peripheral_clock_tick_o,
    output logic fast_osc_run_o,
    output logic fast_osc_gate_o,
    output logic [5:0] fast_osc_frequency_trim_o,
    output logic [3:0] fast_osc_temperature_slope_o
);
    import clk_ctrl_pkg::*;

    if (DIV_CNT_W < 7) begin : g_check
        $error("DIV_CNT_W must be at least 7");
    end

    // ****************************************
    // Declarations
    // ****************************************
    axi_rsp_s rsp_q;
    logic aw_have_q;
    logic w_have_q;
    logic [4:0] wr_idx_q;
    logic [7:0] wr_byte_q;
    logic wr_lane_q;
    logic aw_take;
    logic w_take;
    logic wr_fire;
    logic wr_en;
    logic [7:0] rd_byte;
    logic [4:0] rd_idx;

    logic clk_out_en_q;
    src_e main_source_select_q;
    src_e active_q;
    logic [3:0] prescaler_division_q;
    logic prescaler_enable_q;
    logic main_settings_lock_q;
    switch_e sw_q;
    logic [3:0] stab_q;
    logic run_in_standby_q;
    logic [5:0] freq_trim_q;
    logic [3:0] temp_trim_q;
    logic cal_lock_q;
    fosc_e fo_q;
    logic [2:0] gate_cnt_q;
    logic system_clock_pin_output_q;
    logic run_q;
    logic gate_q;

    logic [3:0] requested;
    logic main_wr_ok;
    logic cal_wr_ok;

    // Index is mapped to a register
    function automatic logic is_mapped(input logic [4:0] idx);
        return (idx == `IDX_CTRL_A) || (idx == `IDX_CTRL_B) || (idx == `IDX_LOCK) ||
            (idx == `IDX_STATUS) || (idx == `IDX_FOSC_CTRL) ||
            (idx == `IDX_FOSC_FREQ) || (idx == `IDX_FOSC_TEMP);
    endfunction

    // ****************************************
    // Bus slave
    // ****************************************
    assign aw_take = axi_i.awvalid && rsp_q.awready;
    assign w_take = axi_i.wvalid && rsp_q.wready;
    assign wr_fire = aw_have_q && w_have_q && !rsp_q.bvalid;
    assign wr_en = wr_fire && wr_lane_q;
    assign rd_idx = axi_i.araddr[`IDX_RANGE];

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            rsp_q <= '0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            wr_idx_q <= '0;
            wr_byte_q <= '0;
            wr_lane_q <= 1'b0;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                wr_idx_q <= axi_i.awaddr[`IDX_RANGE];
                rsp_q.awready <= 1'b0;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
                rsp_q.awready <= 1'b1;
            end else begin
                rsp_q.awready <= !aw_have_q;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wr_byte_q <= axi_i.wdata[7:0];
                wr_lane_q <= axi_i.wstrb[0];
                rsp_q.wready <= 1'b0;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
                rsp_q.wready <= 1'b1;
            end else begin
                rsp_q.wready <= !w_have_q;
            end
            if (wr_fire) begin
                rsp_q.bvalid <= 1'b1;
                rsp_q.bresp <= is_mapped(wr_idx_q) ? `RESP_OKAY : `RESP_DECERR;
            end else if (axi_i.bready && rsp_q.bvalid) begin
                rsp_q.bvalid <= 1'b0;
            end
            if (axi_i.arvalid && rsp_q.arready) begin
                rsp_q.arready <= 1'b0;
                rsp_q.rvalid <= 1'b1;
                rsp_q.rdata <= {24'h000000, rd_byte};
                rsp_q.rresp <= is_mapped(rd_idx) ? `RESP_OKAY : `RESP_DECERR;
            end else if (axi_i.rready && rsp_q.rvalid) begin
                rsp_q.rvalid <= 1'b0;
                rsp_q.arready <= 1'b1;
            end else begin
                rsp_q.arready <= !rsp_q.rvalid;
            end
        end
    end

    assign axi_o = rsp_q;

    // Read mux; reserved bits stay zero
    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_idx)
            `IDX_CTRL_A: begin
                rd_byte[`A_OUT] = clk_out_en_q;
                rd_byte[`A_SEL] = main_source_select_q;
            end
            `IDX_CTRL_B: begin
                rd_byte[`B_DIV] = prescaler_division_q;
                rd_byte[`B_PEN] = prescaler_enable_q;
            end
            `IDX_LOCK: rd_byte[`LOCK_BIT] = main_settings_lock_q;
            `IDX_STATUS: begin
                rd_byte[`ST_FLAGS] = stab_q;
                rd_byte[`ST_PEND] = (sw_q == SW_PEND);
            end
            `IDX_FOSC_CTRL: rd_byte[`FOSC_RSTBY] = run_in_standby_q;
            `IDX_FOSC_FREQ: rd_byte[`FREQ_FIELD] = freq_trim_q;
            `IDX_FOSC_TEMP: begin
                rd_byte[`CALLOCK_BIT] = cal_lock_q;
                rd_byte[`TEMP_FIELD] = temp_trim_q;
            end
            default: rd_byte = 8'h00;
        endcase
    end

    // ****************************************
    // Write permission
    // ****************************************
    assign main_wr_ok = wr_en && protect_open_i && !main_settings_lock_q;
    // Trims refuse under fuse lock, or main lock with the fast source active
    assign cal_wr_ok = wr_en && protect_open_i && !cal_lock_q &&
        !(main_settings_lock_q && active_q == SRC_FAST);

    // ****************************************
    // Main clock control
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            clk_out_en_q <= `RST_OUT;
            main_source_select_q <= src_e'(`RST_SEL);
            prescaler_division_q <= `RST_DIV;
            prescaler_enable_q <= `RST_PEN;
        end else if (main_wr_ok && wr_idx_q == `IDX_CTRL_A) begin
            clk_out_en_q <= wr_byte_q[`A_OUT];
            main_source_select_q <= src_e'(wr_byte_q[`A_SEL]);
        end else if (main_wr_ok && wr_idx_q == `IDX_CTRL_B) begin
            prescaler_division_q <= wr_byte_q[`B_DIV];
            prescaler_enable_q <= wr_byte_q[`B_PEN];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            main_settings_lock_q <= 1'b0;
        end else if (main_wr_ok && wr_idx_q == `IDX_LOCK && wr_byte_q[`LOCK_BIT]) begin
            main_settings_lock_q <= 1'b1;
        end
    end

    // ****************************************
    // Source switching and status
    // ****************************************
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            requested[i] = periph_request_i[i] || (active_q == src_e'(i[1:0])) ||
                ((sw_q == SW_PEND) && (main_source_select_q == src_e'(i[1:0])));
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            stab_q <= '0;
        end else begin
            stab_q[0] <= requested[0] && (fo_q == FO_OPEN);
            stab_q[3:1] <= requested[3:1] & source_ready_i[3:1];
        end
    end

    // Switch only once the new source is stable
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            sw_q <= SW_IDLE;
            active_q <= src_e'(`RST_SEL);
        end else begin
            unique case (sw_q)
                SW_IDLE: sw_q <= SW_IDLE;
                SW_PEND: begin
                    if (stab_q[main_source_select_q]) begin
                        active_q <= main_source_select_q;
                        sw_q <= SW_IDLE;
                    end
                end
            endcase
            // A new request beats a completion in the same cycle
            if (main_wr_ok && wr_idx_q == `IDX_CTRL_A &&
                src_e'(wr_byte_q[`A_SEL]) != active_q) begin
                sw_q <= SW_PEND;
            end
        end
    end

    assign main_source_active_o = active_q;

    // ****************************************
    // Fast oscillator control and trims
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            run_in_standby_q <= 1'b0;
        end else if (wr_en && protect_open_i && wr_idx_q == `IDX_FOSC_CTRL) begin
            run_in_standby_q <= wr_byte_q[`FOSC_RSTBY];
        end
    end

    // Factory trims follow the fuse frequency select
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            freq_trim_q <= fuse_frequency_select_i ? FREQ_TRIM_20 : FREQ_TRIM_16;
            temp_trim_q <= fuse_frequency_select_i ? TEMP_TRIM_20 : TEMP_TRIM_16;
            cal_lock_q <= fuse_calibration_lock_i;
        end else if (cal_wr_ok && wr_idx_q == `IDX_FOSC_FREQ) begin
            freq_trim_q <= wr_byte_q[`FREQ_FIELD];
        end else if (cal_wr_ok && wr_idx_q == `IDX_FOSC_TEMP) begin
            temp_trim_q <= wr_byte_q[`TEMP_FIELD];
        end
    end

    assign fast_osc_frequency_trim_o = freq_trim_q;
    assign fast_osc_temperature_slope_o = temp_trim_q;

    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
        end else begin
            run_q <= run_in_standby_q || requested[0];
        end
    end

    assign fast_osc_run_o = run_q;

    // Gate sequence: analog start (skipped in run standby), then count oscillator cycles
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            fo_q <= FO_OFF;
            gate_cnt_q <= '0;
            gate_q <= 1'b0;
        end else if (!requested[0]) begin
            fo_q <= FO_OFF;
            gate_cnt_q <= '0;
            gate_q <= 1'b0;
        end else begin
            unique case (fo_q)
                FO_OFF: fo_q <= run_in_standby_q ? FO_COUNT : FO_WARM;
                FO_WARM: begin
                    if (source_ready_i[0]) begin
                        fo_q <= FO_COUNT;
                    end
                end
                FO_COUNT: begin
                    if (fast_osc_tick_i) begin
                        gate_cnt_q <= gate_cnt_q + 3'h1;
                        if (gate_cnt_q == `GATE_CYCLES - 3'h1) begin
                            fo_q <= FO_OPEN;
                            gate_q <= 1'b1;
                        end
                    end
                end
                FO_OPEN: fo_q <= FO_OPEN;
            endcase
        end
    end

    assign fast_osc_gate_o = gate_q;

    // ****************************************
    // Clock out pin and prescaler
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            system_clock_pin_output_q <= 1'b0;
        end else if (clk_out_en_q && !(sleep_i && !sysclk_in_use_i)) begin
            system_clock_pin_output_q <= !system_clock_pin_output_q;
        end else begin
            system_clock_pin_output_q <= 1'b0;
        end
    end

    assign system_clock_pin_output_o = system_clock_pin_output_q;

    clk_prescaler #(
        .CNT_W(DIV_CNT_W)
    ) u_prescaler (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .enable_i(prescaler_enable_q),
        .code_i(prescaler_division_q),
        .tick_o(peripheral_clock_tick_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    AST_LOCK_STICKY: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        main_settings_lock_q |=> main_settings_lock_q)
        else $error("main settings lock released without reset");

    AST_LOCK_BLOCKS: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        main_settings_lock_q && wr_fire |=>
        $stable({clk_out_en_q, main_source_select_q, prescaler_division_q}))
        else $error("main control changed while locked");

    AST_KEY_REQUIRED: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !protect_open_i |=> $stable({run_in_standby_q, prescaler_enable_q, freq_trim_q}))
        else $error("protected register changed without key");

    AST_FUSE_LOCK: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        cal_lock_q && $past(cal_lock_q) |-> $stable({freq_trim_q, temp_trim_q}))
        else $error("trim changed under fuse lock");

    AST_SWITCH_DONE: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sw_q == SW_PEND && stab_q[main_source_select_q] && !main_wr_ok |=>
        sw_q == SW_IDLE && active_q == $past(main_source_select_q))
        else $error("source switch did not complete");

    AST_GATE_REQ: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !requested[0] |=> fo_q == FO_OFF)
        else $error("fast gate open without request");

    AST_SYSTEM_CLOCK_PIN_OUTPUT_SLEEP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        sleep_i && !sysclk_in_use_i |=> !system_clock_pin_output_q)
        else $error("clock out toggles in sleep");

    AST_STANDBY_RUN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        run_in_standby_q |=> fast_osc_run_o)
        else $error("fast oscillator stopped in run standby");

endmodule

// ### rtl/clk_ctrl_defs.svh
// Register indices, field slices, reset values and timing counts of the clock controller.
// Assumes inclusion by bare name from the controller design file and the bench.
`ifndef CLK_CTRL_DEFS_SVH
`define CLK_CTRL_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL_A 5'h00
`define IDX_CTRL_B 5'h01
`define IDX_LOCK 5'h02
`define IDX_STATUS 5'h03
`define IDX_FOSC_CTRL 5'h10
`define IDX_FOSC_FREQ 5'h11
`define IDX_FOSC_TEMP 5'h12
`define IDX_RANGE 6:2

// Field slices within the low byte
`define A_OUT 7
`define A_SEL 1:0
`define B_DIV 4:1
`define B_PEN 0
`define LOCK_BIT 0
`define ST_FLAGS 7:4
`define ST_PEND 0
`define FOSC_RSTBY 1
`define FREQ_FIELD 5:0
`define TEMP_FIELD 3:0
`define CALLOCK_BIT 7

// Reset values
`define RST_OUT 1'b0
`define RST_SEL 2'h0
`define RST_DIV 4'h8
`define RST_PEN 1'b1

// Fast oscillator gate opens after this many oscillator cycles
`define GATE_CYCLES 3'h4

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

// ### rtl/clk_ctrl_pkg.sv
// Types shared by the clock controller: bus structs, state enums, ratio decode.
// Assumes the defines header is on the include path.
package clk_ctrl_pkg;

    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axi_rsp_s;

    typedef enum logic [1:0] {
        SRC_FAST = 2'h0,
        SRC_ULP = 2'h1,
        SRC_XTAL = 2'h2,
        SRC_EXT = 2'h3
    } src_e;

    typedef enum logic {
        SW_IDLE = 1'b0,
        SW_PEND = 1'b1
    } switch_e;

    typedef enum logic [1:0] {
        FO_OFF = 2'h0,
        FO_WARM = 2'h1,
        FO_COUNT = 2'h3,
        FO_OPEN = 2'h2
    } fosc_e;

    // Division code to ratio; reserved codes fall back to two
    function automatic logic [6:0] div_ratio(input logic [3:0] code);
        logic [6:0] r;
        r = 7'h02;
        unique case (code)
            4'h0: r = 7'h02;
            4'h1: r = 7'h04;
            4'h2: r = 7'h08;
            4'h3: r = 7'h10;
            4'h4: r = 7'h20;
            4'h5: r = 7'h40;
            4'h8: r = 7'h06;
            4'h9: r = 7'h0A;
            4'hA: r = 7'h0C;
            4'hB: r = 7'h18;
            4'hC: r = 7'h30;
            default: r = 7'h02;
        endcase
        return r;
    endfunction

endpackage

// ### rtl/clk_prescaler.sv
// Peripheral clock prescaler: one-cycle tick per divided period of the main clock.
// Assumes the main clock is the module clock; a new ratio is taken only at a period end.
`timescale 1ns/1ps
module clk_prescaler #(
    parameter int CNT_W = 7
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic enable_i,
    input wire logic [3:0] code_i,
    output logic tick_o
);
    import clk_ctrl_pkg::*;

    if (CNT_W < 7) begin : g_check
        $error("clk_prescaler: CNT_W must be at least 7");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] ratio_q;
    logic tick_q;

    // ****************************************
    // Divider
    // ****************************************
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            cnt_q <= '0;
            ratio_q <= CNT_W'(1);
            tick_q <= 1'b0;
        end else if (cnt_q >= ratio_q - CNT_W'(1)) begin
            cnt_q <= '0;
            tick_q <= 1'b1;
            // Ratio reloads only on a wrap, so no short period
            ratio_q <= enable_i ? CNT_W'(div_ratio(code_i)) : CNT_W'(1);
        end else begin
            cnt_q <= cnt_q + CNT_W'(1);
            tick_q <= 1'b0;
        end
    end

    assign tick_o = tick_q;

    AST_TICK_ON_WRAP: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        tick_q |-> cnt_q == '0)
        else $error("prescaler tick away from period start");

    AST_RATIO_HELD: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        (cnt_q != '0) && $past(cnt_q != '0) |-> $stable(ratio_q))
        else $error("prescaler ratio changed mid period");

endmodule

// ### tb/main_clock_select_prescale_control_tb_top.sv
// Self-checking bench for the clock controller register block.
// Assumes the design files and the defines header are compiled first.
`timescale 1ns/1ps
`include "clk_ctrl_defs.svh"
module main_clock_select_prescale_control_tb_top;
    import clk_ctrl_pkg::*;
    // ************
    // Signals
    // ************
    logic clk_sys_i, sys_rst_i, prot, slp, inuse, otick, fsel, flock, pin, ptick, frun, fgate;
    logic [3:0] preq, srdy, tslope;
    logic [5:0] ftrim;
    axi_req_s req;
    axi_rsp_s rsp;
    src_e act;
    int error_cnt, cmp_count, per;
    logic [7:0] bv [12] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0B, 8'h11, 8'h13, 8'h15,
        8'h17, 8'h19, 8'h18};
    int ratios [12] = '{2, 4, 8, 16, 32, 64, 6, 10, 12, 24, 48, 1};

    main_clock_select_prescale_control #(.FREQ_TRIM_16(6'h11), .FREQ_TRIM_20(6'h2A),
        .TEMP_TRIM_16(4'h3), .TEMP_TRIM_20(4'hC), .DIV_CNT_W(7)) u_dut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .axi_i(req), .axi_o(rsp),
        .protect_open_i(prot), .sleep_i(slp), .sysclk_in_use_i(inuse),
        .periph_request_i(preq), .source_ready_i(srdy), .fast_osc_tick_i(otick),
        .fuse_frequency_select_i(fsel), .fuse_calibration_lock_i(flock),
        .system_clock_pin_output_o(pin), .main_source_active_o(act),
        .peripheral_clock_tick_o(ptick), .fast_osc_run_o(frun), .fast_osc_gate_o(fgate),
        .fast_osc_frequency_trim_o(ftrim), .fast_osc_temperature_slope_o(tslope));

    initial begin
        clk_sys_i = 1'b0;
        forever #50 clk_sys_i = ~clk_sys_i;
    end
    // ************
    // Tasks
    // ************
    task automatic chk(input logic [39:0] g, input logic [39:0] e);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error at %0t: got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic wr(input logic [4:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic a, w, b;
        logic [1:0] r;
        n = 0;
        b = 1'b0;
        @(posedge clk_sys_i);
        req.awvalid <= 1'b1;
        req.awaddr <= {1'b0, idx, 2'b00};
        req.wvalid <= 1'b1;
        req.wdata <= {24'h000000, d};
        req.wstrb <= 4'hF;
        req.bready <= 1'b1;
        while (!b && n < 50) begin
            @(negedge clk_sys_i);
            a = req.awvalid & rsp.awready;
            w = req.wvalid & rsp.wready;
            b = rsp.bvalid;
            r = rsp.bresp;
            @(posedge clk_sys_i);
            if (a) req.awvalid <= 1'b0;
            if (w) req.wvalid <= 1'b0;
            if (b) req.bready <= 1'b0;
            n++;
        end
        chk({b, r}, {1'b1, er});
    endtask
    task automatic rd(input logic [4:0] idx, input logic [7:0] e, input logic [1:0] er);
        int n;
        logic a, v;
        logic [1:0] r;
        logic [31:0] d;
        n = 0;
        v = 1'b0;
        @(posedge clk_sys_i);
        req.arvalid <= 1'b1;
        req.araddr <= {1'b0, idx, 2'b00};
        req.rready <= 1'b1;
        while (!v && n < 50) begin
            @(negedge clk_sys_i);
            a = req.arvalid & rsp.arready;
            v = rsp.rvalid;
            r = rsp.rresp;
            d = rsp.rdata;
            @(posedge clk_sys_i);
            if (a) req.arvalid <= 1'b0;
            if (v) req.rready <= 1'b0;
            n++;
        end
        chk({v, r, (er === `RESP_OKAY) ? d : 32'h0}, {1'b1, er, 24'h0, e});
    endtask
    task automatic wk(input logic [4:0] idx, input logic [7:0] d);
        wr(idx, d, `RESP_OKAY);
    endtask
    task automatic rk(input logic [4:0] idx, input logic [7:0] e);
        rd(idx, e, `RESP_OKAY);
    endtask
    task automatic period(output int p);
        int n;
        n = 0;
        p = 0;
        @(negedge clk_sys_i);
        while (ptick !== 1'b1 && n < 200) begin
            @(negedge clk_sys_i);
            n++;
        end
        do begin
            @(negedge clk_sys_i);
            p++;
        end while (ptick !== 1'b1 && p < 200);
    endtask
    task automatic tog();
        logic p;
        @(negedge clk_sys_i);
        p = pin;
        @(negedge clk_sys_i);
        chk(pin, !p);
    endtask
    task automatic ft(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            otick <= 1'b1;
            @(posedge clk_sys_i);
            otick <= 1'b0;
        end
        @(negedge clk_sys_i);
    endtask
    task automatic wait_act(input src_e s);
        int n;
        n = 0;
        while (act !== s && n < 100) begin
            @(negedge clk_sys_i);
            n++;
        end
        chk(act, s);
    endtask
    task automatic rst();
        @(posedge clk_sys_i);
        sys_rst_i <= 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // ************
    // Tests
    // ************
    initial begin
        repeat (30000) @(posedge clk_sys_i);
        error_cnt++;
        wrap_up();
    end
    initial begin
        {prot, slp, inuse, otick, fsel, flock, preq, srdy} = '0;
        req = '0;
        error_cnt = 0;
        cmp_count = 0;
        sys_rst_i = 1'b1;
        cyc(2);
        sys_rst_i <= 1'b0;
        rk(`IDX_CTRL_A, 8'h00);
        rk(`IDX_CTRL_B, 8'h11);
        rk(`IDX_LOCK, 8'h00);
        rk(`IDX_STATUS, 8'h00);
        rk(`IDX_FOSC_CTRL, 8'h00);
        rk(`IDX_FOSC_FREQ, 8'h11);
        rk(`IDX_FOSC_TEMP, 8'h03);
        rd(5'h04, 8'h00, `RESP_DECERR);
        period(per);
        chk(per, 6);
        $display("reset values done");
        wk(`IDX_CTRL_B, 8'h00);
        rk(`IDX_CTRL_B, 8'h11);
        @(posedge clk_sys_i);
        prot <= 1'b1;
        wk(`IDX_CTRL_B, 8'hFF);
        rk(`IDX_CTRL_B, 8'h1F);
        wk(`IDX_CTRL_A, 8'hFC);
        rk(`IDX_CTRL_A, 8'h80);
        wk(`IDX_FOSC_FREQ, 8'hFF);
        rk(`IDX_FOSC_FREQ, 8'h3F);
        wk(`IDX_FOSC_TEMP, 8'hFF);
        rk(`IDX_FOSC_TEMP, 8'h0F);
        chk({ftrim, tslope}, 10'h3FF);
        wr(5'h05, 8'h01, `RESP_DECERR);
        wk(`IDX_STATUS, 8'hFF);
        rk(`IDX_STATUS, 8'h00);
        $display("access done");
        for (int i = 0; i < 12; i++) begin
            wk(`IDX_CTRL_B, bv[i]);
            period(per);
            period(per);
            chk(per, ratios[i]);
        end
        $display("prescaler done");
        tog();
        @(posedge clk_sys_i);
        slp <= 1'b1;
        cyc(2);
        repeat (3) begin
            @(negedge clk_sys_i);
            chk(pin, 1'b0);
        end
        @(negedge clk_sys_i);
        chk(pin, 1'b0);
        @(posedge clk_sys_i);
        inuse <= 1'b1;
        tog();
        @(posedge clk_sys_i);
        slp <= 1'b0;
        wk(`IDX_CTRL_A, 8'h00);
        cyc(2);
        @(negedge clk_sys_i);
        chk(pin, 1'b0);
        $display("clock pin done");
        wk(`IDX_CTRL_A, 8'h01);
        rk(`IDX_STATUS, 8'h01);
        chk(act, SRC_FAST);
        @(posedge clk_sys_i);
        srdy <= 4'hE;
        for (int s = 1; s < 4; s++) begin
            if (s > 1) wk(`IDX_CTRL_A, 8'(s));
            wait_act(src_e'(s));
            rk(`IDX_STATUS, 8'h10 << s);
        end
        chk(frun, 1'b0);
        wk(`IDX_FOSC_CTRL, 8'h02);
        @(negedge clk_sys_i);
        chk({frun, fgate}, 2'b10);
        @(posedge clk_sys_i);
        preq <= 4'h1;
        cyc(3);
        ft(3);
        chk(fgate, 1'b0);
        ft(1);
        chk(fgate, 1'b1);
        rk(`IDX_STATUS, 8'h90);
        preq <= 4'h0;
        cyc(2);
        @(negedge clk_sys_i);
        chk({frun, fgate}, 2'b10);
        rk(`IDX_STATUS, 8'h80);
        wk(`IDX_CTRL_A, 8'h00);
        ft(4);
        wait_act(SRC_FAST);
        rk(`IDX_STATUS, 8'h10);
        $display("source switch done");
        wk(`IDX_LOCK, 8'h01);
        wk(`IDX_LOCK, 8'h00);
        wk(`IDX_CTRL_A, 8'h80);
        rk(`IDX_CTRL_A, 8'h00);
        wk(`IDX_CTRL_B, 8'h01);
        rk(`IDX_CTRL_B, 8'h18);
        wk(`IDX_FOSC_FREQ, 8'h05);
        rk(`IDX_FOSC_FREQ, 8'h3F);
        $display("lock done");
        fsel <= 1'b1;
        flock <= 1'b1;
        rst();
        rk(`IDX_FOSC_FREQ, 8'h2A);
        rk(`IDX_FOSC_TEMP, 8'h8C);
        wk(`IDX_FOSC_FREQ, 8'h01);
        rk(`IDX_FOSC_FREQ, 8'h2A);
        wk(`IDX_CTRL_B, 8'h03);
        rk(`IDX_CTRL_B, 8'h03);
        @(negedge clk_sys_i);
        chk(fgate, 1'b0);
        @(posedge clk_sys_i);
        srdy <= 4'hF;
        ft(4);
        chk(fgate, 1'b1);
        $display("fuse done");
        wrap_up();
    end
endmodule
